// file: bsfo_pkg.sv
/*
 * package for the sideband flush ordering block: request modes, states,
 * carrier structs and timing constants.
 * assumes a single 100 MHz bus clock.
 */
package bsfo_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_PS     = 10000;
	localparam int unsigned WATCHDOG_MIN_NS   = 1500000;
	// least time: round up
	localparam int unsigned WATCHDOG_CYCLES   =
		(WATCHDOG_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WDOG_W            = 18;
	localparam int unsigned DEV_NUM_W         = 5;
	localparam logic [4:0]  MAX_FORWARD_DEV   = 5'h0f;
	localparam int unsigned RELEASE_DELAY     = 2;
	localparam int unsigned POST_CNT_W        = 4;

	// ----------------------------------------
	// modes and states
	// ----------------------------------------
	typedef enum logic [1:0] {
		BSFO_MODE_NONE,
		guaranteed_access_time_mode,
		non_guaranteed_access_mode,
		interrupt_controller_flush_mode
	} bsfo_mode_t;

	typedef enum logic [2:0] {
		BSFO_IDLE,
		BSFO_DRAIN,
		BSFO_ACK,
		BSFO_REARB
	} bsfo_state_t;

	// processor-bus request from the outbound queue
	typedef struct packed {
		logic                 valid;
		logic                 is_config;
		logic                 is_ordering;
		logic [DEV_NUM_W-1:0] dev_num;
	} bsfo_outreq_t;

	// PCI-side completion of an outbound cycle
	typedef struct packed {
		logic done;
		logic retry;
		logic is_read;
	} bsfo_pcires_t;

endpackage : bsfo_pkg

// file: bsfo_bridge.sv
/*
 * sideband flush ordering, retry forwarding and config watchdog of the bridge.
 * assumes inputs synchronous to clk; posted-write engine and PCI master
 * outside report through the strobes below.
 */
`timescale 1ns/1ps
`default_nettype none
module bsfo_bridge
	import bsfo_pkg::*;
#(
	parameter int unsigned WATCHDOG_LIMIT = WATCHDOG_CYCLES
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// sideband request lines
	input  wire logic         flush_buffers_request_n,
	input  wire logic         memory_request_n,
	output var  logic         memory_acknowledge_n,
	// inbound posted writes
	input  wire logic         posted_write_accept,
	input  wire logic         posted_write_done,
	input  wire logic         posted_write_retried,
	output var  logic         inbound_post_enable,
	// arbitration
	output var  logic         expansion_bus_request,
	output var  logic         priority_agent_bus_request_n,
	output var  logic         reissue_grant,
	// outbound requests
	input  wire bsfo_outreq_t out_req,
	input  wire bsfo_pcires_t pci_res,
	output var  logic         forward_to_pci,
	output var  logic         proc_retry_response,
	output var  logic         watchdog_claim,
	output var  bsfo_mode_t   active_mode
);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	bsfo_mode_t  next_mode;
	bsfo_state_t state;
	logic [POST_CNT_W-1:0] pending;
	logic [1:0]  rel_cnt;
	logic        retried_seen;
	logic        outbound_busy;
	logic        config_wait;
	logic [WDOG_W-1:0] wdog;

	always_comb begin
		unique case ({flush_buffers_request_n, memory_request_n})
			2'b00:   next_mode = guaranteed_access_time_mode;
			2'b01:   next_mode = non_guaranteed_access_mode;
			2'b10:   next_mode = interrupt_controller_flush_mode;
			default: next_mode = BSFO_MODE_NONE;
		endcase
	end

	// ----------------------------------------
	// posted write count
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pending <= '0;
		end else if (posted_write_accept && !posted_write_done) begin
			pending <= pending + 1'b1;
		end else if (posted_write_done && !posted_write_accept && pending != '0) begin
			pending <= pending - 1'b1;
		end
	end

	// ----------------------------------------
	// sideband sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state                        <= BSFO_IDLE;
			active_mode                  <= BSFO_MODE_NONE;
			expansion_bus_request        <= 1'b0;
			priority_agent_bus_request_n <= 1'b1;
			memory_acknowledge_n         <= 1'b1;
			reissue_grant                <= 1'b0;
			rel_cnt                      <= '0;
			retried_seen                 <= 1'b0;
		end else begin
			reissue_grant <= 1'b0;
			case (state)
				BSFO_IDLE: begin
					active_mode <= next_mode;
					if (next_mode != BSFO_MODE_NONE) begin
						if (pending != '0) begin
							state                 <= BSFO_DRAIN;
							expansion_bus_request <= 1'b1;
							priority_agent_bus_request_n <= 1'b0;
							retried_seen          <= 1'b0;
						end else begin
							state                <= BSFO_ACK;
							memory_acknowledge_n <= 1'b0;
						end
					end
				end
				BSFO_DRAIN: begin
					// a stuck target would deadlock if the request were held
					if (posted_write_retried && !retried_seen) begin
						retried_seen <= 1'b1;
						rel_cnt      <= 2'(RELEASE_DELAY);
					end
					if (retried_seen && rel_cnt != '0) begin
						rel_cnt <= rel_cnt - 2'd1;
					end
					if (retried_seen && rel_cnt == 2'd1) begin
						expansion_bus_request <= 1'b0;
					end
					if (pending == '0) begin
						state                        <= BSFO_ACK;
						expansion_bus_request        <= 1'b0;
						priority_agent_bus_request_n <= 1'b1;
						memory_acknowledge_n         <= 1'b0;
					end
				end
				BSFO_ACK: begin
					if (posted_write_retried) begin
						// release first so two agents never drive it together
						priority_agent_bus_request_n <= 1'b1;
						state                        <= BSFO_REARB;
					end
					if (next_mode == BSFO_MODE_NONE) begin
						memory_acknowledge_n <= 1'b1;
						active_mode          <= BSFO_MODE_NONE;
						if (!posted_write_retried) begin
							state <= BSFO_IDLE;
						end
					end
				end
				BSFO_REARB: begin
					priority_agent_bus_request_n <= 1'b0;
					if (!priority_agent_bus_request_n) begin
						reissue_grant                <= 1'b1;
						priority_agent_bus_request_n <= 1'b1;
						state <= (memory_acknowledge_n) ? BSFO_IDLE : BSFO_ACK;
					end
					if (next_mode == BSFO_MODE_NONE) begin
						memory_acknowledge_n <= 1'b1;
					end
				end
				default: state <= BSFO_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// outbound ordering and posting gate
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			outbound_busy <= 1'b0;
		end else if (out_req.valid && out_req.is_ordering && !out_req.is_config) begin
			outbound_busy <= 1'b1;
		end else if (pci_res.done) begin
			outbound_busy <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			inbound_post_enable <= 1'b1;
		end else begin
			// mirrors the next busy value: no one-cycle lag after completion
			inbound_post_enable <= !(outbound_busy && !pci_res.done) &&
				!(out_req.valid && out_req.is_ordering && !out_req.is_config);
		end
	end

	// ----------------------------------------
	// forwarding, retry and watchdog
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			forward_to_pci      <= 1'b0;
			proc_retry_response <= 1'b0;
		end else begin
			forward_to_pci      <= out_req.valid &&
				!(out_req.is_config && out_req.dev_num > MAX_FORWARD_DEV);
			proc_retry_response <= pci_res.retry && pci_res.is_read;
		end
	end

	// counter never claims before the full least time
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			config_wait    <= 1'b0;
			wdog           <= '0;
			watchdog_claim <= 1'b0;
		end else begin
			watchdog_claim <= 1'b0;
			if (!config_wait) begin
				wdog <= '0;
				config_wait <= out_req.valid && out_req.is_config &&
					out_req.dev_num > MAX_FORWARD_DEV;
			end else if (wdog >= WDOG_W'(WATCHDOG_LIMIT - 1)) begin
				watchdog_claim <= 1'b1;
				config_wait    <= 1'b0;
			end else begin
				wdog <= wdog + 1'b1;
			end
		end
	end

endmodule : bsfo_bridge
`default_nettype wire

// file: bsfo_monitor.sv
/* port checker for bsfo_bridge.
   assumes it is bound to every bridge instance, one clock. */
`timescale 1ns/1ps
`default_nettype none
module bsfo_monitor
	import bsfo_pkg::*;
#(
	parameter int unsigned WATCHDOG_LIMIT = WATCHDOG_CYCLES
) (
	// clock and reset
	input wire logic         clk,
	input wire logic         reset_n,
	// sideband and drain
	input wire logic         flush_buffers_request_n,
	input wire logic         memory_request_n,
	input wire logic         memory_acknowledge_n,
	input wire logic         posted_write_retried,
	input wire logic         inbound_post_enable,
	input wire logic         expansion_bus_request,
	input wire logic         priority_agent_bus_request_n,
	input wire logic         reissue_grant,
	// outbound
	input wire bsfo_outreq_t out_req,
	input wire bsfo_pcires_t pci_res,
	input wire logic         forward_to_pci,
	input wire logic         proc_retry_response
);
	// ----------------
	// properties
	// ----------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire lines_idle = flush_buffers_request_n & memory_request_n;
	cfg_block_a: assert property (out_req.valid && out_req.is_config && out_req.dev_num > MAX_FORWARD_DEV
		|=> !forward_to_pci) else $error("config access forwarded");
	retry_fwd_a: assert property (pci_res.retry && pci_res.is_read |=> proc_retry_response)
		else $error("pci retry not passed on");
	post_off_a: assert property (out_req.valid && out_req.is_ordering && !out_req.is_config
		|=> !inbound_post_enable) else $error("posting left on");
	post_hold_a: assert property (!inbound_post_enable && !pci_res.done |=> $stable(inbound_post_enable))
		else $error("posting back before completion");
	drain_req_a: assert property ($rose(expansion_bus_request) |-> !priority_agent_bus_request_n
		&& memory_acknowledge_n) else $error("drain start wrong");
	// drop lands two edges after the retry, so it is first sampled on the third
	exp_drop_a: assert property (posted_write_retried && expansion_bus_request |-> ##3 !expansion_bus_request)
		else $error("expansion request held");
	ack_hold_a: assert property (!memory_acknowledge_n && !lines_idle |=> !memory_acknowledge_n)
		else $error("acknowledge dropped early");
	ack_free_a: assert property (!memory_acknowledge_n && lines_idle |=> memory_acknowledge_n)
		else $error("acknowledge not released");
	// a reissue without a fresh low phase would fight another priority agent
	prio_rearb_a: assert property (reissue_grant |-> $past(priority_agent_bus_request_n, 2)
		&& !$past(priority_agent_bus_request_n)) else $error("no rearbitration");
endmodule : bsfo_monitor
bind bsfo_bridge bsfo_monitor #(.WATCHDOG_LIMIT(WATCHDOG_LIMIT)) i_mon (.*);
`default_nettype wire

// file: bsfo_partner.sv
/* sideband requester model.
   assumes the bench pulses go with a mode; lines pulled up. */
`timescale 1ns/1ps
`default_nettype none
module bsfo_partner
	import bsfo_pkg::*;
(
	// bench side
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       go,
	input  wire logic       hold,
	input  wire bsfo_mode_t mode,
	// sideband
	input  wire logic       memory_acknowledge_n,
	output var  logic       flush_buffers_request_n,
	output var  logic       memory_request_n
);
	// ----------------
	// request lines
	// ----------------
	always_ff @(posedge clk) begin
		// hold lets the bench keep the bridge in acknowledge
		if (!reset_n || !(memory_acknowledge_n || hold)) begin
			flush_buffers_request_n <= 1'b1;
			memory_request_n        <= 1'b1;
		end else if (go) begin
			flush_buffers_request_n <= mode == interrupt_controller_flush_mode;
			memory_request_n        <= mode == non_guaranteed_access_mode;
		end
	end
endmodule : bsfo_partner
`default_nettype wire

// file: test_bridge_sideband_flush_ordering.sv
/* bench for bsfo_bridge with the requester model.
   assumes the bridge ports as declared; short watchdog. */
`timescale 1ns/1ps
`default_nettype none
module test_bridge_sideband_flush_ordering
	import bsfo_pkg::*;
;
	// ----------------
	// bench
	// ----------------
	localparam int unsigned WD = 20;
	logic         clk, reset_n, go, hold, fb_n, mr_n, ack_n, post_en, exp_req, prio_n, grant, fwd, pretry, claim;
	logic   [2:0] pw;
	bsfo_mode_t   mode, amode;
	bsfo_outreq_t oq;
	bsfo_pcires_t pr;
	int           n_mismatch, cmp_count, n;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	bsfo_bridge #(.WATCHDOG_LIMIT(WD)) i_dut (.clk, .reset_n, .flush_buffers_request_n(fb_n),
		.memory_request_n(mr_n), .memory_acknowledge_n(ack_n), .posted_write_accept(pw[2]),
		.posted_write_done(pw[1]), .posted_write_retried(pw[0]), .inbound_post_enable(post_en),
		.expansion_bus_request(exp_req), .priority_agent_bus_request_n(prio_n), .reissue_grant(grant),
		.out_req(oq), .pci_res(pr), .forward_to_pci(fwd), .proc_retry_response(pretry),
		.watchdog_claim(claim), .active_mode(amode));
	bsfo_partner i_req (.clk, .reset_n, .go, .hold, .mode, .memory_acknowledge_n(ack_n),
		.flush_buffers_request_n(fb_n), .memory_request_n(mr_n));
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic check(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t value differs", $time);
		end
	endtask : check
	task automatic pulse(input logic [2:0] w, input bsfo_outreq_t o, input bsfo_pcires_t p);
		@(posedge clk) {pw, oq, pr} <= {w, o, p};
		@(posedge clk) {pw, oq, pr} <= '0;
		#1;
	endtask : pulse
	task automatic req(input bsfo_mode_t m);
		@(posedge clk) {go, mode} <= {1'b1, m};
		@(posedge clk) go <= 1'b0;
		#1;
	endtask : req
	task automatic t_modes();
		for (int m = 1; m < 4; m++) begin
			pulse(3'b100, '0, '0);
			req(bsfo_mode_t'(m));
			for (n = 0; n < 40 && exp_req !== 1'b1; n++) tick();
			check(amode === bsfo_mode_t'(m), 1'b1);
			check(prio_n, 1'b0);
			check(ack_n, 1'b1);
			pulse(3'b010, '0, '0);
			for (n = 0; n < 40 && ack_n !== 1'b0; n++) tick();
			check(ack_n | exp_req, 1'b0);
			for (n = 0; n < 40 && ack_n !== 1'b1; n++) tick();
			check(ack_n, 1'b1);
		end
		req(guaranteed_access_time_mode);
		for (n = 0; n < 4 && ack_n !== 1'b0; n++) tick();
		check(ack_n | exp_req, 1'b0);
		for (n = 0; n < 40 && ack_n !== 1'b1; n++) tick();
		check(ack_n, 1'b1);
	endtask : t_modes
	task automatic t_retry();
		@(posedge clk) hold <= 1'b1;
		pulse(3'b100, '0, '0);
		pulse(3'b100, '0, '0);
		req(non_guaranteed_access_mode);
		for (n = 0; n < 40 && exp_req !== 1'b1; n++) tick();
		pulse(3'b001, '0, '0);
		tick();
		tick();
		check(exp_req | prio_n, 1'b0);
		pulse(3'b010, '0, '0);
		check(ack_n, 1'b1);
		pulse(3'b010, '0, '0);
		for (n = 0; n < 40 && ack_n !== 1'b0; n++) tick();
		pulse(3'b001, '0, '0);
		for (n = 0; n < 10 && grant !== 1'b1; n++) tick();
		check(grant & prio_n, 1'b1);
		check(ack_n, 1'b0);
		@(posedge clk) hold <= 1'b0;
		for (n = 0; n < 40 && ack_n !== 1'b1; n++) tick();
		check(ack_n, 1'b1);
	endtask : t_retry
	task automatic t_out();
		pulse(3'b0, '{1'b1, 1'b1, 1'b0, 5'h10}, '0);
		check(fwd, 1'b0);
		// n counts from the launch edge, one before the request is taken
		for (n = 1; n < 3 * WD && claim !== 1'b1; n++) tick();
		check(claim & (n > WD), 1'b1);
		pulse(3'b0, '{1'b1, 1'b1, 1'b0, 5'h0f}, '0);
		check(fwd, 1'b1);
		pulse(3'b0, '{1'b1, 1'b0, 1'b1, 5'h00}, '0);
		check(post_en, 1'b0);
		pulse(3'b0, '0, '{1'b0, 1'b1, 1'b1});
		check(pretry, 1'b1);
		check(post_en, 1'b0);
		pulse(3'b0, '0, '{1'b1, 1'b0, 1'b0});
		check(post_en, 1'b1);
	endtask : t_out
	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		{reset_n, go, hold, mode, pw, oq, pr} = '0;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		@(posedge clk) reset_n <= 1'b1;
		t_modes();
		t_retry();
		t_out();
		print_verdict();
	end
	// run needs well under a thousand cycles
	initial begin
		#50000;
		n_mismatch++;
		print_verdict();
	end
endmodule : test_bridge_sideband_flush_ordering
`default_nettype wire
